//--- fm_tune_pkg.sv
// Register map, field positions, reset values and timing for the FM
// subcarrier tuning register bank.
// Assumes a 20 MHz system clock and a 32-bit classic Wishbone master.
package fm_tune_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [3:0] IDX_DEVIATION   = 4'h5; // deviation_gain_reg
  localparam logic [3:0] IDX_LOOP_SWITCH = 4'h6; // loop_switch_ctrl_reg
  localparam logic [3:0] IDX_SYNTH_HIGH  = 4'h7; // synth_code_high_reg
  localparam logic [3:0] IDX_LOCK_STATUS = 4'h8; // lock_status_reg
  localparam logic [3:0] IDX_MEAS_HIGH   = 4'h9; // measured_freq_high_reg

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int GAIN_LSB      = 0;  // Loop gain factor, bits 5..0
  localparam int GAIN_W        = 6;
  localparam int SW_SYNTH_BIT  = 2;  // synth_connect_switch
  localparam int SW_BIAS_BIT   = 3;  // Second bias switch
  localparam int SW_LOOP_BIT   = 4;  // loop_connect_switch
  localparam int SW_INPUT_BIT  = 5;  // Input switch
  localparam int CODE_B0_BIT   = 6;  // Synthesis code bit 0
  localparam int CODE_B1_BIT   = 7;  // Synthesis code bit 1
  localparam int ST_CARRIER    = 0;  // Carrier present
  localparam int ST_IN_TOL     = 1;  // Readback within tolerance
  localparam int ST_MEAS_B0    = 2;  // Measured code bit 0
  localparam int ST_MEAS_B1    = 3;  // Measured code bit 1
  localparam int ST_AT_FREQ    = 4;  // Carrier at wanted frequency
  localparam int ST_FRESH      = 5;  // New readback since last read

  // ----------------------------------------------------------------------
  // Reset values and special codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] DEV_RESET       = 8'h35; // 54.4 kHz, half dev
  localparam logic [7:0] SW_RESET        = 8'h04; // VCO on synthesis
  localparam logic [7:0] SYNTH_RESET     = 8'haf; // 7.00 MHz high byte
  localparam logic [7:0] DEV_CAL_2V      = 8'h03; // 2 V VCO step
  localparam logic [7:0] DEV_CAL_1V      = 8'h23; // 1 V VCO step
  localparam logic [9:0] CODE_MIN        = 10'd500;  // 5 MHz
  localparam logic [9:0] CODE_MAX        = 10'd1000; // 10 MHz
  localparam logic [9:0] CODE_TOLERANCE  = 10'd2;    // +/-20 kHz
  localparam logic [31:0] BUS_ZERO       = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLOCK_HZ        = 20_000_000;
  localparam int READBACK_MS     = 100;  // Readback refresh period
  localparam int READBACK_CYCLES = (CLOCK_HZ / 1000) * READBACK_MS;

endpackage

//--- freq_readback_sampler.sv
// Periodic capture of the VCO frequency measurement.
// Assumes vco_code_i is a settled 10-bit code from the analog counter
// and is synchronous to clock_i.
module freq_readback_sampler
  import fm_tune_pkg::*;
#(
  parameter int PERIOD_CYCLES = READBACK_CYCLES
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  // Raw measurement in
  input  wire logic [9:0] vco_code_i,
  // Held sample out
  output logic      [9:0] sample_o,
  output logic            sample_pulse_o
);

  // ----------------------------------------------------------------------
  // Period counter and sample hold
  // ----------------------------------------------------------------------
  logic [31:0] tick_r;      // Cycles into the current period
  logic [31:0] tick_nxt;
  logic [9:0]  sample_r;    // Last captured code
  logic [9:0]  sample_nxt;
  logic        pulse_r;     // One-cycle capture marker
  logic        pulse_nxt;

  // Next values: the readback only moves once per period, so a host
  // polling faster sees the same value repeated
  always_comb begin
    tick_nxt   = tick_r + 32'd1;
    sample_nxt = sample_r;
    pulse_nxt  = 1'b0;
    if (tick_r >= 32'(PERIOD_CYCLES - 1)) begin
      tick_nxt   = 32'd0;
      sample_nxt = vco_code_i;
      pulse_nxt  = 1'b1;
    end
  end

  // Registers
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tick_r   <= 32'd0;
      sample_r <= 10'h000;
      pulse_r  <= 1'b0;
    end else begin
      tick_r   <= tick_nxt;
      sample_r <= sample_nxt;
      pulse_r  <= pulse_nxt;
    end
  end

  assign sample_o       = sample_r;
  assign sample_pulse_o = pulse_r;

endmodule

//--- fm_subcarrier_tune_sequencer.sv
// Register bank of the FM subcarrier demodulator tuning logic.
// Assumes a classic Wishbone master, one 20 MHz clock and a
// synchronous active-high reset; analog status comes in synchronous.
module fm_subcarrier_tune_sequencer
  import fm_tune_pkg::*;
#(
  parameter int READBACK_PERIOD = READBACK_CYCLES
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Analog side inputs
  input  wire logic [9:0]  vco_code_i,
  input  wire logic        carrier_present_i,
  input  wire logic        carrier_at_freq_i,
  // Analog side controls
  output logic      [9:0]  synth_code_o,
  output logic             synth_code_valid_o,
  output logic             synth_load_o,
  output logic      [5:0]  loop_gain_factor_o,
  output logic             deviation_half_o,
  output logic             cal_step_2v_o,
  output logic             cal_step_1v_o,
  output logic             synth_connect_switch_o,
  output logic             loop_connect_switch_o,
  output logic             bias_switch_o,
  output logic             input_switch_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Distance between two 10-bit codes
  function automatic logic [9:0] code_distance(input logic [9:0] a,
                                               input logic [9:0] b);
    code_distance = (a > b) ? (a - b) : (b - a);
  endfunction

  // Byte address to register index; upper bits must be zero
  function automatic logic [3:0] reg_index(input logic [7:0] adr);
    reg_index = adr[5:2];
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0]  dev_r;        // deviation_gain_reg
  logic [7:0]  dev_nxt;
  logic [7:0]  sw_r;         // loop_switch_ctrl_reg
  logic [7:0]  sw_nxt;
  logic [7:0]  synth_r;      // synth_code_high_reg
  logic [7:0]  synth_nxt;
  logic        load_r;       // Synthesis launch pulse
  logic        load_nxt;
  logic        fresh_r;      // New readback since status read
  logic        fresh_nxt;
  logic        ack_r;        // Bus acknowledge
  logic        ack_nxt;
  logic [31:0] rdata_r;      // Registered read data
  logic [31:0] rdata_nxt;
  logic [9:0]  meas_code;    // Held VCO measurement
  logic        meas_pulse;   // Measurement refreshed
  logic [9:0]  code_full;    // Programmed 10-bit code
  logic        in_tol;       // Measurement near programmed code
  logic        req;          // New bus request this cycle
  logic        wr_en;        // Write taking effect this cycle
  logic        rd_status;    // Status read taking effect
  logic        mapped;       // Address hits the bank
  logic [3:0]  idx;          // Decoded register index
  logic [7:0]  status_byte;  // Live lock_status_reg view

  // ----------------------------------------------------------------------
  // Frequency readback
  // ----------------------------------------------------------------------
  freq_readback_sampler #(
    .PERIOD_CYCLES (READBACK_PERIOD)
  ) u_sampler (
    .clock_i        (clock_i),
    .reset_i        (reset_i),
    .vco_code_i     (vco_code_i),
    .sample_o       (meas_code),
    .sample_pulse_o (meas_pulse)
  );

  // ----------------------------------------------------------------------
  // Decode and derived state
  // ----------------------------------------------------------------------

  // Request is taken once; ack drops the cycle after it is given
  assign req    = wb_cyc_i && wb_stb_i && !ack_r;
  assign idx    = reg_index(wb_adr_i);
  assign mapped = (wb_adr_i[7:6] == 2'b00) && (wb_adr_i[1:0] == 2'b00) &&
                  (idx >= IDX_DEVIATION) && (idx <= IDX_MEAS_HIGH);
  // Only the low byte lane carries register data
  assign wr_en     = req && wb_we_i && wb_sel_i[0] && mapped;
  assign rd_status = req && !wb_we_i && (idx == IDX_LOCK_STATUS) && mapped;

  assign code_full = {synth_r, sw_r[CODE_B1_BIT], sw_r[CODE_B0_BIT]};

  assign in_tol = code_distance(meas_code, code_full) <= CODE_TOLERANCE;

  // Status view; low measured bits sit in bits 3..2
  always_comb begin
    status_byte              = 8'h00;
    status_byte[ST_CARRIER]  = carrier_present_i;
    status_byte[ST_IN_TOL]   = in_tol;
    status_byte[ST_MEAS_B0]  = meas_code[0];
    status_byte[ST_MEAS_B1]  = meas_code[1];
    status_byte[ST_AT_FREQ]  = carrier_at_freq_i;
    status_byte[ST_FRESH]    = fresh_r;
  end

  // ----------------------------------------------------------------------
  // Register bank next state
  // ----------------------------------------------------------------------

  // Writes land at the acknowledge edge; unmapped writes are dropped
  always_comb begin
    dev_nxt   = dev_r;
    sw_nxt    = sw_r;
    synth_nxt = synth_r;
    load_nxt  = 1'b0;
    if (wr_en) begin
      unique case (idx)
        IDX_DEVIATION:   dev_nxt   = wb_dat_i[7:0];
        IDX_LOOP_SWITCH: begin
          sw_nxt   = wb_dat_i[7:0];
          // Code bits live here too, so relaunch synthesis
          load_nxt = 1'b1;
        end
        IDX_SYNTH_HIGH: begin
          synth_nxt = wb_dat_i[7:0];
          load_nxt  = 1'b1;
        end
        // Read-only registers ignore writes
        default: load_nxt = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Fresh-readback flag
  // ----------------------------------------------------------------------

  // A refresh in the same cycle as the clearing read wins, so a
  // sample is never silently missed by a polling host
  always_comb begin
    fresh_nxt = fresh_r;
    if (rd_status) begin
      fresh_nxt = 1'b0;
    end
    if (meas_pulse) begin
      fresh_nxt = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------------

  // One wait state: answer in the cycle after the request is seen
  always_comb begin
    ack_nxt   = req;
    rdata_nxt = BUS_ZERO;
    if (req && !wb_we_i && mapped) begin
      unique case (idx)
        IDX_DEVIATION:   rdata_nxt = {24'h000000, dev_r};
        IDX_LOOP_SWITCH: rdata_nxt = {24'h000000, sw_r};
        IDX_SYNTH_HIGH:  rdata_nxt = {24'h000000, synth_r};
        IDX_LOCK_STATUS: rdata_nxt = {24'h000000, status_byte};
        IDX_MEAS_HIGH:   rdata_nxt = {24'h000000, meas_code[9:2]};
        default:         rdata_nxt = BUS_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      dev_r   <= DEV_RESET;
      sw_r    <= SW_RESET;
      synth_r <= SYNTH_RESET;
      load_r  <= 1'b0;
      fresh_r <= 1'b0;
      ack_r   <= 1'b0;
      rdata_r <= BUS_ZERO;
    end else begin
      dev_r   <= dev_nxt;
      sw_r    <= sw_nxt;
      synth_r <= synth_nxt;
      load_r  <= load_nxt;
      fresh_r <= fresh_nxt;
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  assign synth_code_o = code_full;
  assign synth_code_valid_o = (code_full >= CODE_MIN) &&
                              (code_full <= CODE_MAX);
  assign synth_load_o = load_r;

  assign loop_gain_factor_o = dev_r[GAIN_LSB +: GAIN_W];
  assign deviation_half_o   = dev_r[SW_INPUT_BIT];
  assign cal_step_2v_o = (dev_r == DEV_CAL_2V);
  assign cal_step_1v_o = (dev_r == DEV_CAL_1V);

  assign synth_connect_switch_o = sw_r[SW_SYNTH_BIT];
  assign loop_connect_switch_o  = sw_r[SW_LOOP_BIT];
  assign bias_switch_o          = sw_r[SW_BIAS_BIT];
  assign input_switch_o         = sw_r[SW_INPUT_BIT];

endmodule

//--- fm_tune_props.sv
// Port checker for the FM tuning register bank.
// Assumes a classic Wishbone master that holds a request until ack.
module fm_tune_checker
  import fm_tune_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  // Analog controls
  input wire logic [9:0]  synth_code_o,
  input wire logic        synth_code_valid_o,
  input wire logic        synth_load_o,
  input wire logic [5:0]  loop_gain_factor_o,
  input wire logic        cal_step_2v_o,
  input wire logic        cal_step_1v_o,
  input wire logic        synth_connect_switch_o,
  input wire logic        loop_connect_switch_o
);
  // Acked low-lane write; registers land with the ack
  logic wr_ok;
  assign wr_ok = wb_ack_o && wb_we_i && wb_sel_i[0];
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  property p_ack_lat;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held");
  property p_code_hi;
    wr_ok && wb_adr_i == 8'h1c |-> synth_code_o[9:2] == wb_dat_i[7:0];
  endproperty
  a_code_hi: assert property (p_code_hi) else $error("code hi");
  property p_code_lo;
    wr_ok && wb_adr_i == 8'h18 |-> synth_code_o[1:0] == wb_dat_i[7:6]
      && loop_connect_switch_o == wb_dat_i[4]
      && synth_connect_switch_o == wb_dat_i[2];
  endproperty
  a_code_lo: assert property (p_code_lo) else $error("ctrl");
  property p_load;
    wr_ok && (wb_adr_i == 8'h18 || wb_adr_i == 8'h1c)
      |-> synth_load_o ##1 !synth_load_o;
  endproperty
  a_load: assert property (p_load) else $error("load pulse");
  property p_valid;
    synth_code_valid_o == (synth_code_o >= 10'd500
      && synth_code_o <= 10'd1000);
  endproperty
  a_valid: assert property (p_valid) else $error("valid");
  property p_gain;
    wr_ok && wb_adr_i == 8'h14 |-> loop_gain_factor_o == wb_dat_i[5:0];
  endproperty
  a_gain: assert property (p_gain) else $error("gain");
  property p_cal;
    wr_ok && wb_adr_i == 8'h14 |-> cal_step_2v_o == (wb_dat_i[7:0]
      == 8'h03) && cal_step_1v_o == (wb_dat_i[7:0] == 8'h23);
  endproperty
  a_cal: assert property (p_cal) else $error("cal step");
endmodule

bind fm_subcarrier_tune_sequencer fm_tune_checker fm_tune_checker_i (
  .clock_i(clock_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .synth_code_o(synth_code_o), .synth_code_valid_o(synth_code_valid_o),
  .synth_load_o(synth_load_o), .loop_gain_factor_o(loop_gain_factor_o),
  .cal_step_2v_o(cal_step_2v_o), .cal_step_1v_o(cal_step_1v_o),
  .synth_connect_switch_o(synth_connect_switch_o),
  .loop_connect_switch_o(loop_connect_switch_o)
);

//--- wb_host_model.sv
// Host controller model: classic Wishbone master for the bank.
// Assumes the slave answers with ack; a lost ack raises timeout_o.
module wb_host_model (
  // Clock and bus answer
  input  wire logic        clock_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_i,
  // Bus request
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o,
  output logic             timeout_o
);
  // Idle bus from time zero
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
    timeout_o = 1'b0;
  end
  // whole cycle
  // Holds every signal until ack is sampled, then drops cyc and stb
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [7:0] d, input logic [3:0] s, output logic [31:0] q);
    int n;
    @(posedge clock_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_sel_o <= s;
    wb_dat_o <= {24'h0, d};
    for (n = 0; n < 16; n++) begin
      @(posedge clock_i);
      if (wb_ack_i === 1'b1) break;
    end
    q = wb_dat_i;
    if (n == 16) timeout_o <= 1'b1;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
  endtask
endmodule

//--- fm_subcarrier_tune_sequencer_tb_top.sv
// Bench for the FM tuning bank: the host model runs register
// sequences, the bench plays the analog measurement side.
module fm_subcarrier_tune_sequencer_tb_top
  import fm_tune_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_i, reset_i, cyc, stb, we, ack, tmo;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic [9:0]  vco, code, meas;
  logic        cp, af, vld, load, half, c2, c1, ssw, lsw, bsw, isw;
  logic [5:0]  gain;
  int          fail_count = 0;
  int          compares = 0;
  // Synthesis table: high byte, ctrl bits 7..6, code
  logic [7:0]  hi [6] = '{8'haf, 8'hb4, 8'ha6, 8'h7c, 8'hfa, 8'hfa};
  logic [1:0]  lo [6] = '{2'b10, 2'b00, 2'b01, 2'b11, 2'b00, 2'b01};
  int          cd [6] = '{702, 720, 665, 499, 1000, 1001};
  int          off [4] = '{2, -2, 3, -3};
  logic [7:0]  dv [3] = '{8'h03, 8'h23, 8'h36};
  // Watchdog offsets and the error count each should leave
  int          err_off [6] = '{3, -1, 3, -3, 4, -6};
  int          err_cnt [6] = '{1, 0, 1, 2, 3, 4};
  int          errs;
  logic [9:0]  reference_frequency, stepped_frequency;
  // Model VCO slope in codes per volt; arbitrary
  localparam int CODES_PER_VOLT = 46;
  // Short readback period keeps the run brief
  fm_subcarrier_tune_sequencer #(.READBACK_PERIOD(20))
    fm_subcarrier_tune_sequencer_i (
    .clock_i(clock_i), .reset_i(reset_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .vco_code_i(vco), .carrier_present_i(cp), .carrier_at_freq_i(af),
    .synth_code_o(code), .synth_code_valid_o(vld),
    .synth_load_o(load), .loop_gain_factor_o(gain),
    .deviation_half_o(half), .cal_step_2v_o(c2), .cal_step_1v_o(c1),
    .synth_connect_switch_o(ssw), .loop_connect_switch_o(lsw),
    .bias_switch_o(bsw), .input_switch_o(isw));
  wb_host_model host_i (.clock_i(clock_i), .wb_dat_i(rdat),
    .wb_ack_i(ack), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat), .timeout_o(tmo));
  // 20 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task automatic wrap_up;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_i.xfer(1'b1, a, d, 4'h1, q);
  endtask
  task automatic rdc(input logic [7:0] a, e, input string nm);
    host_i.xfer(1'b0, a, 8'h00, 4'h1, q);
    check(nm, q, {24'h0, e});
  endtask
  task automatic poll;
    int n;
    for (n = 0; n < 40; n++) begin
      host_i.xfer(1'b0, 8'h20, 8'h00, 4'h1, q);
      if (q[5] === 1'b1) break;
    end
    if (n == 40) begin
      fail_count++;
      wrap_up();
    end
  endtask
  // A lost ack ends the run
  always @(posedge clock_i) begin
    if (tmo === 1'b1) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    reset_i = 1'b1;
    vco = 10'd0;
    cp = 1'b0;
    af = 1'b0;
    repeat (10) @(posedge clock_i);
    reset_i <= 1'b0;
    rdc(8'h14, DEV_RESET, "dev");
    rdc(8'h18, SW_RESET, "ctrl");
    rdc(8'h1c, SYNTH_RESET, "synth");
    check("code", code, 10'd700);
    for (int i = 0; i < 6; i++) begin
      wr(8'h1c, hi[i]);
      wr(8'h18, {lo[i], 6'h04});
      check("code", code, cd[i]);
      check("valid", vld, cd[i] >= 500 && cd[i] <= 1000);
      rdc(8'h1c, hi[i], "hi");
    end
    wr(8'h1c, 8'haf);
    wr(8'h18, 8'h84);
    for (int k = 0; k < 4; k++) begin
      meas = 10'(702 + off[k]);
      vco <= meas;
      cp <= k[0];
      af <= k[1];
      // settle: wait out a full refresh
      poll();
      poll();
      check("status", q, {26'h0, 1'b1, k[1], meas[1:0],
        off[k] * off[k] <= 4, k[0]});
      rdc(8'h24, meas[9:2], "meas");
      rdc(8'h20, {3'h0, k[1], meas[1:0], off[k] * off[k] <= 4, k[0]},
        "fresh");
    end
    wr(8'h18, 8'h10);
    check("switches", {isw, lsw, bsw, ssw}, 4'b0100);
    wr(8'h18, 8'h38);
    check("switches", {isw, lsw, bsw, ssw}, 4'b1110);
    for (int j = 0; j < 3; j++) begin
      wr(8'h14, dv[j]);
      check("dev", {c1, c2, half, gain}, {dv[j] == 8'h23,
        dv[j] == 8'h03, dv[j][5], dv[j][5:0]});
    end
    wr(8'h28, 8'h55);
    rdc(8'h28, 8'h00, "unmapped");
    rdc(8'h15, 8'h00, "misaligned");
    host_i.xfer(1'b1, 8'h14, 8'h11, 4'h0, q);
    wr(8'h24, 8'h00);
    rdc(8'h14, 8'h36, "dev kept");
    rdc(8'h24, meas[9:2], "meas kept");
    // Close the left loop, code bits set back to 10
    wr(8'h18, 8'h90);
    check("closed", {lsw, ssw}, 2'b10);
    // watchdog: two fresh readbacks per sample, the second one judged
    errs = 0;
    for (int m = 0; m < 6; m++) begin
      vco <= 10'(702 + err_off[m]);
      poll();
      poll();
      if (q[1] === 1'b1) errs = 0;
      else errs++;
      check("errs", errs, err_cnt[m]);
    end
    // limit reached: open loop, back to synthesis
    check("limit", errs, 4);
    wr(8'h18, 8'h84);
    check("stop", {lsw, ssw}, 2'b01);
    // one retry of the synthesis step
    wr(8'h1c, 8'haf);
    vco <= 10'd702;
    poll();
    poll();
    reference_frequency[1:0] = q[3:2];
    host_i.xfer(1'b0, 8'h24, 8'h00, 4'h1, q);
    reference_frequency[9:2] = q[7:0];
    check("ref", reference_frequency, 10'd702);
    // 2 V drive step moves the model VCO
    wr(8'h14, DEV_CAL_2V);
    check("cal", {c1, c2}, 2'b01);
    vco <= 10'(702 + 2 * CODES_PER_VOLT);
    // a whole refresh passes before measuring
    poll();
    poll();
    stepped_frequency[1:0] = q[3:2];
    host_i.xfer(1'b0, 8'h24, 8'h00, 4'h1, q);
    stepped_frequency[9:2] = q[7:0];
    // slope over the 2 V step
    check("slope", (stepped_frequency - reference_frequency) / 2,
      CODES_PER_VOLT);
    // right channel after left, loop opened and code bits back to 00
    wr(8'h18, 8'h04);
    wr(8'h1c, 8'hb4);
    check("right", code, 10'd720);
    reset_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    rdc(8'h14, DEV_RESET, "dev");
    check("code", code, 10'd700);
    wrap_up();
  end
endmodule
